// ---- src/scma_decode.sv ----
// connection word field decoder for one output timeslot
`timescale 1ns/10ps
module scma_decode (
  input wire logic [23:0] word_i,
  input wire logic [1:0] rate_i,
  output logic [4:0] src_group_o,
  output logic [9:0] src_chan_o,
  output logic src_stream_b_o,
  output logic [7:0] msg_byte_o
);
  // bits 23..15 are never looked at
  assign src_group_o = word_i[scma_pkg::GRP_FLD_HI:scma_pkg::GRP_FLD_LO]; // RQ2
  always_comb begin
    case (scma_pkg::scma_rate_t'(rate_i))
      scma_pkg::SCMA_R65: src_chan_o = word_i[9:0]; // RQ3
      scma_pkg::SCMA_R32: src_chan_o = {1'b0, word_i[9:1]}; // RQ4
      scma_pkg::SCMA_R16: src_chan_o = {2'h0, word_i[9:2]}; // RQ5
      scma_pkg::SCMA_R8: src_chan_o = {3'h0, word_i[9:3]}; // RQ6
      default: src_chan_o = word_i[9:0];
    endcase
  end
  // 65 Mbps has only stream a
  assign src_stream_b_o = (rate_i != 2'h0) & word_i[0]; // RQ4
  assign msg_byte_o = word_i[scma_pkg::MSG_FLD_HI:0]; // RQ7
endmodule : scma_decode

// ---- src/scma_pkg.sv ----
// package of constants for the connection memory access block
//
// Functional notes
// RQ1: software writes zero into word bits 23 to 15; they have no function.
// RQ2: in connection mode word bits 14 to 10 select source group 0 to 31.
// RQ3: at 65 Mbps bits 9 to 0 are the source channel 0 to 1023.
// RQ4: at 32 Mbps bits 9 to 1 are the channel, bit 0 picks stream a or b.
// RQ5: at 16 Mbps bits 9 to 2 are channel, bit 0 stream, bit 1 kept zero.
// RQ6: at 8 Mbps bits 9 to 3 are channel, bit 0 stream, bits 2 to 1 kept 00.
// RQ7: in message mode bits 7 to 0 go out msb first; bits 9 to 8 are unused.
// RQ8: a window reads and writes each word's low byte, one byte per address.
// RQ9: a 32-bit window access covers four consecutive words in one cycle.
// RQ10: window access is big-endian, top byte lane at the lowest address.
// RQ11: each output group owns a 1024-byte block from 020000 up to 027c00.
// RQ12: 65 Mbps: a 000-3ff; 32 Mbps: a 000-1ff, b 200-3ff.
// RQ13: 16M a 000-0ff, b 100-1ff; 8M a 000-07f, b 080-0ff; above is an error.
// RQ14: timeslot k of a stream sits at the stream range start plus k.
// RQ15: an access to an error address drives bus_error_n low.
package scma_pkg;
  // ==========================================================
  // window map
  localparam logic [17:0] WIN_BASE = 18'h20000;
  localparam logic [17:0] WIN_LAST = 18'h27fff;
  localparam int GRP_LSB = 10;
  // ==========================================================
  // connection word fields
  localparam int GRP_FLD_HI = 14;
  localparam int GRP_FLD_LO = 10;
  localparam int CH_FLD_HI = 9;
  localparam int MSG_FLD_HI = 7;
  localparam logic [23:0] WORD_RST = 24'h000000;
  // ==========================================================
  // rate codes
  typedef enum logic [1:0] {
    SCMA_R65 = 2'h0,
    SCMA_R32 = 2'h1,
    SCMA_R16 = 2'h2,
    SCMA_R8 = 2'h3
  } scma_rate_t;
  // ==========================================================
  // byte-lane sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
endpackage : scma_pkg

// ---- src/scma_top.sv ----
// connection memory with host access, low-byte window and output reader
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module scma_top #(
  parameter int GROUPS = 32,
  parameter int SLOTS = 1024
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // host port
  input wire logic [17:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] size_i,
  input wire logic word_sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic bus_error_n_o,
  // per group output rate and mode
  input wire logic [2*GROUPS-1:0] group_rate_i,
  input wire logic [GROUPS-1:0] group_msg_i,
  // switching side read port
  input wire logic [4:0] out_group_i,
  input wire logic [9:0] out_slot_i,
  input wire logic out_stream_b_i,
  input wire logic out_load_i,
  output logic [4:0] source_group_select_o,
  output logic [9:0] src_chan_o,
  output logic src_stream_b_o,
  output logic msg_bit_o,
  output logic msg_valid_o
);
  // field widths below are fixed to this geometry
  if (GROUPS != 32 || SLOTS != 1024) begin : g_bad_cfg
    $error("scma_top: only 32 groups of 1024 slots are supported");
  end
  localparam int DEPTH = GROUPS * SLOTS;

  // ==========================================================
  // storage: full 24-bit connection word per output timeslot
  logic [23:0] connection_word [DEPTH];

  // ==========================================================
  // window address decode
  logic in_win;
  logic [4:0] win_grp;
  logic [9:0] win_off;
  logic [1:0] win_rate;
  logic [9:0] last_off;
  logic [9:0] lim;
  logic win_bad;
  logic access;
  logic [2:0] nbytes;
  assign in_win = (addr_i >= scma_pkg::WIN_BASE)
                  && (addr_i <= scma_pkg::WIN_LAST); // RQ11
  assign win_grp = addr_i[14:scma_pkg::GRP_LSB]; // RQ11
  assign win_off = addr_i[scma_pkg::GRP_LSB-1:0];
  assign win_rate = group_rate_i[2*win_grp +: 2];
  assign nbytes = (size_i == scma_pkg::SZ_WORD) ? 3'h4 :
                  (size_i == scma_pkg::SZ_HALF) ? 3'h2 : 3'h1; // RQ9
  assign last_off = win_off + 10'(nbytes - 3'h1);

  // highest valid offset for the group's rate
  function automatic logic [9:0] rate_limit(input logic [1:0] r);
    case (scma_pkg::scma_rate_t'(r))
      scma_pkg::SCMA_R65: rate_limit = 10'h3ff; // RQ12
      scma_pkg::SCMA_R32: rate_limit = 10'h3ff; // RQ12
      scma_pkg::SCMA_R16: rate_limit = 10'h1ff; // RQ13
      scma_pkg::SCMA_R8: rate_limit = 10'h0ff; // RQ13
      default: rate_limit = 10'h3ff;
    endcase
  endfunction : rate_limit

  assign lim = rate_limit(win_rate);
  // access may not straddle a group block nor cross its limit
  assign win_bad = (last_off < win_off) || (last_off > lim)
                   || (size_i == 2'h3); // RQ13
  assign access = (wr_i | rd_i) & clk_en_i;

  // full-word access port outside the window: word index in addr
  logic [14:0] word_idx;
  logic word_bad;
  assign word_idx = addr_i[14:0];
  assign word_bad = addr_i[17:15] != 3'h0;

  logic next_err;
  assign next_err = word_sel_i ? word_bad : (!in_win || win_bad); // RQ15

  // byte lane mapping, big endian: lane 3 at lowest address
  logic [31:0] win_rd;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      logic [14:0] idx;
      logic en;
      assign idx = {win_grp, win_off + 10'(b)}; // RQ14
      assign en = (3'(b) < nbytes);
      // first byte in the top used lane
      assign win_rd[8*(3-b) +: 8] = en ?
             connection_word[idx][7:0] : 8'h00; // RQ10
    end
  endgenerate

  // realign so that a byte or half read lands in the low lanes
  logic [31:0] win_rd_al;
  assign win_rd_al = (size_i == scma_pkg::SZ_WORD) ? win_rd :
                     (size_i == scma_pkg::SZ_HALF) ? {16'h0000, win_rd[31:16]}
                     : {24'h000000, win_rd[31:24]};
  logic [31:0] wdata_al;
  assign wdata_al = (size_i == scma_pkg::SZ_WORD) ? wdata_i :
                    (size_i == scma_pkg::SZ_HALF) ? {wdata_i[15:0], 16'h0000}
                    : {wdata_i[7:0], 24'h000000};

  // ==========================================================
  // write path
  integer i;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < DEPTH; i++)
        connection_word[i] <= scma_pkg::WORD_RST;
    end else if (clk_en_i && wr_i && !next_err) begin
      if (word_sel_i)
        connection_word[word_idx] <= wdata_i[23:0];
      else begin
        for (i = 0; i < 4; i++)
          if (3'(i) < nbytes)
            connection_word[{win_grp, win_off + 10'(i)}][7:0]
              <= wdata_al[8*(3-i) +: 8]; // RQ8 RQ9 RQ10
      end
    end
  end

  // ==========================================================
  // read data and bus error, one cycle after the strobe
  logic [31:0] next_rdata;
  assign next_rdata = word_sel_i ? {8'h00, connection_word[word_idx]}
                                 : win_rd_al; // RQ8
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
      bus_error_n_o <= 1'b1;
    end else if (clk_en_i) begin
      bus_error_n_o <= !(access && next_err); // RQ15
      if (rd_i && !next_err)
        rdata_o <= next_rdata;
      else
        rdata_o <= 32'h00000000;
    end
  end

  // ==========================================================
  // switching side: word lookup and message serialiser
  logic [9:0] out_off;
  logic [1:0] out_rate;
  logic [14:0] out_idx;
  logic [23:0] out_word;
  assign out_rate = group_rate_i[2*out_group_i +: 2];
  // stream b sits right after stream a's range
  assign out_off = (out_stream_b_i && out_rate != 2'h0) ?
                   out_slot_i + ((rate_limit(out_rate) >> 1) + 10'h001)
                   : out_slot_i; // RQ14 RQ12
  assign out_idx = {out_group_i, out_off};
  assign out_word = connection_word[out_idx];

  logic [4:0] dec_grp;
  logic [9:0] dec_chan;
  logic dec_b;
  logic [7:0] dec_msg;
  scma_decode u_dec (
    .word_i(out_word),
    .rate_i(out_rate),
    .src_group_o(dec_grp),
    .src_chan_o(dec_chan),
    .src_stream_b_o(dec_b),
    .msg_byte_o(dec_msg)
  );

  logic [7:0] shreg;
  logic [3:0] bits_left;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_group_select_o <= 5'h00;
      src_chan_o <= 10'h000;
      src_stream_b_o <= 1'b0;
      shreg <= 8'h00;
      bits_left <= 4'h0;
    end else if (clk_en_i) begin
      if (out_load_i && group_msg_i[out_group_i]) begin
        shreg <= dec_msg; // RQ7
        bits_left <= 4'h8;
      end else if (bits_left != 4'h0) begin
        shreg <= {shreg[6:0], 1'b0}; // RQ7
        bits_left <= bits_left - 4'h1;
      end
      if (out_load_i && !group_msg_i[out_group_i]) begin
        source_group_select_o <= dec_grp; // RQ2
        src_chan_o <= dec_chan; // RQ3 RQ4 RQ5 RQ6
        src_stream_b_o <= dec_b;
      end
    end
  end
  assign msg_bit_o = shreg[7];
  assign msg_valid_o = bits_left != 4'h0;

  // ==========================================================
  // checks
  default clocking cb_chk @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_bad_access;
    access && next_err;
  endsequence

  sequence s_good_read;
    clk_en_i && rd_i && !next_err;
  endsequence

  sequence s_win_read;
    clk_en_i && rd_i && !word_sel_i && in_win;
  endsequence

  sequence s_msg_load;
    clk_en_i && out_load_i && group_msg_i[out_group_i];
  endsequence

  sequence s_conn_load;
    clk_en_i && out_load_i && !group_msg_i[out_group_i];
  endsequence

  // a shift step that is not overridden by a fresh load
  sequence s_shift;
    clk_en_i && bits_left != 4'h0
    && !(out_load_i && group_msg_i[out_group_i]);
  endsequence

  // ==========================================================
  // bus error and read data
  AST_BUS_ERROR_N_ON_BAD: assert property ( // RQ15
    s_bad_access |=> !bus_error_n_o)
    else $error("bus error not raised");

  AST_BUS_ERROR_N_CLEAR: assert property ( // RQ15
    clk_en_i && !access |=> bus_error_n_o)
    else $error("bus error without access");

  AST_BUS_ERROR_N_GOOD: assert property ( // RQ15
    access && !next_err |=> bus_error_n_o)
    else $error("bus error on a legal access");

  AST_BAD_RD_ZERO: assert property ( // RQ15
    s_bad_access |=> rdata_o == 32'h00000000)
    else $error("refused access returned data");

  AST_BAD_SIZE: assert property ( // RQ15
    access && !word_sel_i && size_i == 2'h3 |=> !bus_error_n_o)
    else $error("illegal size not refused");

  AST_R16_HIGH: assert property ( // RQ13
    s_win_read ##0 win_rate == 2'h2 && win_off[9] |=> !bus_error_n_o)
    else $error("16M upper half not refused");

  AST_R8_HIGH: assert property ( // RQ13
    clk_en_i && wr_i && !word_sel_i && in_win && win_rate == 2'h3
    && win_off >= 10'h100 |=> !bus_error_n_o)
    else $error("8M upper range not refused");

  AST_R8_LOW_OK: assert property ( // RQ13
    s_win_read ##0 win_rate == 2'h3 && size_i == 2'h0
    && win_off < 10'h100 |=> bus_error_n_o)
    else $error("8M legal byte refused");

  AST_R65_OK: assert property ( // RQ12
    s_win_read ##0 win_rate == 2'h0 && size_i == 2'h0 |=> bus_error_n_o)
    else $error("65M byte refused");

  AST_R32_OK: assert property ( // RQ12
    s_win_read ##0 win_rate == 2'h1 && size_i == 2'h0 |=> bus_error_n_o)
    else $error("32M byte refused");

  AST_WIN_RANGE: assert property ( // RQ11
    clk_en_i && rd_i && !word_sel_i && addr_i < scma_pkg::WIN_BASE
    |=> !bus_error_n_o && rdata_o == 32'h00000000)
    else $error("below window accepted");

  AST_WIN_ABOVE: assert property ( // RQ11
    clk_en_i && rd_i && !word_sel_i && addr_i > scma_pkg::WIN_LAST
    |=> !bus_error_n_o)
    else $error("above window accepted");

  AST_RD_QUIET: assert property ( // RQ8
    clk_en_i && !rd_i |=> rdata_o == 32'h00000000)
    else $error("read data without a read");

  AST_BYTE_RW: assert property ( // RQ8
    s_good_read ##0 !word_sel_i && size_i == 2'h0
    |=> rdata_o[31:8] == 24'h000000)
    else $error("byte read wider than a byte");

  AST_HALF_RW: assert property ( // RQ9
    s_good_read ##0 !word_sel_i && size_i == 2'h1
    |=> rdata_o[31:16] == 16'h0000)
    else $error("half read wider than a half");

  AST_WORD_RD: assert property ( // RQ8
    s_good_read ##0 word_sel_i |=> rdata_o[31:24] == 8'h00)
    else $error("word read above 24 bits");

  // ==========================================================
  // message serialiser
  AST_MSG_MSB: assert property ( // RQ7
    s_msg_load |=> msg_valid_o && msg_bit_o == $past(dec_msg[7]))
    else $error("message msb not first");

  AST_MSG_COUNT: assert property ( // RQ7
    s_msg_load |=> bits_left == 4'h8)
    else $error("message length wrong");

  AST_MSG_SHIFT: assert property ( // RQ7
    s_shift |=> msg_bit_o == $past(shreg[6]))
    else $error("message bit order wrong");

  AST_MSG_END: assert property ( // RQ7
    s_shift ##0 bits_left == 4'h1 |=> !msg_valid_o)
    else $error("message runs past eight bits");

  // ==========================================================
  // connection mode decode
  AST_GRP_FIELD: assert property ( // RQ2
    s_conn_load |=> source_group_select_o == $past(out_word[14:10]))
    else $error("source group field wrong");

  AST_CHAN65: assert property ( // RQ3
    s_conn_load ##0 out_rate == 2'h0
    |=> src_chan_o == $past(out_word[9:0]))
    else $error("65M channel field wrong");

  AST_CHAN8: assert property ( // RQ6
    s_conn_load ##0 out_rate == 2'h3 |=> src_chan_o[9:7] == 3'h0)
    else $error("8M channel too wide");

  AST_STREAM65: assert property ( // RQ4
    s_conn_load ##0 out_rate == 2'h0 |=> !src_stream_b_o)
    else $error("65M picked stream b");

  // frozen clock enable must hold bits_left, the read data and the bus error
  AST_FREEZE: assert property ( // RQ7
    !clk_en_i |=> $stable(bits_left) && $stable(rdata_o)
    && $stable(bus_error_n_o))
    else $error("state moved while frozen");
endmodule : scma_top

// ---- tb/scma_host.sv ----
// host bus master model for the connection memory access block
`timescale 1ns/10ps
module scma_host (
  input wire logic mclk_i,
  output logic [17:0] addr_o,
  output logic [31:0] wdata_o,
  output logic [1:0] size_o,
  output logic word_sel_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    {addr_o, wdata_o, size_o, word_sel_o, wr_o, rd_o} = '0;
  end
  // one strobe per call; slave never stalls, so calls may run back to back
  task automatic acc(input logic w, input logic ws, input logic [1:0] sz,
                     input logic [17:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_o <= w;
    rd_o <= !w;
    word_sel_o <= ws;
    size_o <= sz;
    addr_o <= a;
    wdata_o <= ws ? {17'h00000, d[14:0]} | (d & 32'h0) : d;
  endtask : acc
  // released bus shows no stale address or data
  task automatic idle();
    @(posedge mclk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask : idle
endmodule : scma_host

// ---- tb/tb_top.sv ----
// self-checking bench for the connection memory access block
`timescale 1ns/10ps
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [17:0] addr;
  logic [31:0] wdata, rdata, w, d;
  logic [1:0] size;
  logic word_sel, wr, rd, bus_error_n_n, mbit, mval, src_b;
  logic st_d = 1'b0;
  logic [63:0] grate = '0;
  logic [31:0] gmsg = '0;
  logic [4:0] og = '0;
  logic [4:0] src_g;
  logic [9:0] os = '0;
  logic [9:0] src_c;
  logic osb = 1'b0;
  logic oload = 1'b0;
  logic cen = 1'b1;
  logic [32:0] exp_q[$];
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #25 mclk_i = ~mclk_i;
  scma_host host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata),
    .size_o(size), .word_sel_o(word_sel), .wr_o(wr), .rd_o(rd));
  scma_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(cen),
    .addr_i(addr), .wdata_i(wdata), .size_i(size), .word_sel_i(word_sel),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus_error_n_o(bus_error_n_n),
    .group_rate_i(grate), .group_msg_i(gmsg), .out_group_i(og),
    .out_slot_i(os), .out_stream_b_i(osb), .out_load_i(oload),
    .source_group_select_o(src_g), .src_chan_o(src_c),
    .src_stream_b_o(src_b), .msg_bit_o(mbit), .msg_valid_o(mval));
  // ====================================
  // checking
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  always @(posedge mclk_i) st_d <= wr | rd;
  always @(negedge mclk_i) begin
    if (st_d) begin
      chk("bus_error_n", {31'h0, bus_error_n_n}, {31'h0, exp_q[0][32]});
      chk("rdata", rdata, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  // ====================================
  // stimulus helpers
  function automatic logic [17:0] wa(input int g, input int o);
    return 18'h20000 + 18'(g * 1024 + o);
  endfunction : wa
  task automatic bus(input logic w_, ws, input logic [1:0] sz,
                     input logic [17:0] a, input logic [31:0] dd,
                     input logic ok, input logic [31:0] e);
    exp_q.push_back({ok, e});
    host.acc(w_, ws, sz, a, dd);
  endtask : bus
  task automatic load(input logic [4:0] g, input logic [9:0] s, b);
    @(posedge mclk_i);
    og <= g;
    os <= s;
    osb <= b;
    oload <= 1'b1;
    @(posedge mclk_i);
    oload <= 1'b0;
    @(negedge mclk_i);
  endtask : load
  task automatic msg(input logic [4:0] g, input logic [9:0] s, input logic b,
                     input logic [7:0] e);
    load(g, s, b);
    for (int i = 7; i >= 0; i--) begin
      chk("msg_bit", {31'h0, mbit}, {31'h0, e[i]});
      chk("msg_valid", {31'h0, mval}, 32'h1);
      @(negedge mclk_i);
    end
    chk("msg_valid", {31'h0, mval}, 32'h0);
  endtask : msg
  // ====================================
  // main sequence
  initial begin
    w = $urandom(32'hb9f0d7cf);
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk_i);
      grate <= {32{r[1:0]}};
      w = {9'h000, 5'(r * 7 + 3), 10'($urandom)};
      if (r == 2) w[1] = 1'b0;
      if (r == 3) w[2:1] = 2'h0;
      bus(1, 1, 2'h2, 18'(3 * 1024 + 5), w, 1, 0);
      bus(0, 1, 2'h2, 18'(3 * 1024 + 5), 0, 1, w);
      bus(0, 0, 2'h0, wa(3, 5), 0, 1, {24'h0, w[7:0]});
      host.idle();
      load(3, 5, 0);
      chk("group", {27'h0, src_g}, {27'h0, w[14:10]});
      chk("chan", {22'h0, src_c}, {22'h0, w[9:0] >> r});
      chk("stream", {31'h0, src_b}, {31'h0, (r != 0) & w[0]});
    end
    @(posedge mclk_i);
    grate <= {32{2'h1}};
    gmsg[3] <= 1'b1;
    d = $urandom;
    bus(1, 0, 2'h2, wa(3, 8), d, 1, 0);
    bus(0, 0, 2'h0, wa(3, 8), 0, 1, {24'h0, d[31:24]});
    bus(0, 0, 2'h1, wa(3, 10), 0, 1, {16'h0, d[15:0]});
    bus(0, 1, 2'h2, 18'(3 * 1024 + 11), 0, 1, {24'h0, d[7:0]});
    bus(1, 0, 2'h0, wa(3, 'h207), {24'h0, w[7:0]}, 1, 0);
    host.idle();
    msg(3, 9, 0, d[23:16]);
    msg(3, 7, 1, w[7:0]);
    // freeze the block for three edges in the middle of a message
    load(3, 9, 0);
    @(posedge mclk_i);
    cen <= 1'b0;
    repeat (3) @(posedge mclk_i);
    cen <= 1'b1;
    @(negedge mclk_i);
    chk("frozen_bit", {31'h0, mbit}, {31'h0, d[22]});
    chk("frozen_valid", {31'h0, mval}, 32'h1);
    repeat (8) @(posedge mclk_i);
    @(posedge mclk_i);
    grate <= {32{2'h3}};
    bus(1, 0, 2'h0, wa(3, 'h100), 32'h5a, 0, 0);
    bus(0, 0, 2'h0, wa(3, 'hff), 0, 1, 0);
    bus(0, 0, 2'h3, wa(3, 0), 0, 0, 0);
    bus(0, 0, 2'h0, 18'h1ffff, 0, 0, 0);
    bus(0, 0, 2'h0, 18'h28000, 0, 0, 0);
    host.idle();
    @(posedge mclk_i);
    grate <= {32{2'h2}};
    bus(0, 0, 2'h0, wa(3, 'h200), 0, 0, 0);
    bus(0, 0, 2'h0, wa(3, 'h1ff), 0, 1, 0);
    host.idle();
    @(posedge mclk_i);
    grate <= '0;
    bus(0, 0, 2'h0, wa(3, 'h100), 0, 1, 0);
    bus(0, 0, 2'h2, wa(31, 'h3fc), 0, 1, 0);
    host.idle();
    repeat (3) @(posedge mclk_i);
    wrap_up();
  end
endmodule : tb_top
